// *** bench/eiom_mapper_tb.sv ***
// self-checking bench of the expanded i/o function mapper
// assumes the mapper, its package and the unit model are compiled first
`timescale 1ns/100ps
`include "eiom_regs.svh"

module eiom_mapper_tb
    import eiom_pkg::*;
;
    logic sys_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sav = 0, menu = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, seed = 32'h9038_e8df, r;
    logic [15:0] sw = 0, ctrl = 0, in_pin, out_pin, nfy, nhold;
    logic [4:0] key_code, lk;
    logic [EIOM_SCR_W-1:0] scr_num, ln;
    logic [31:0] rdata;
    logic key_stb, scr_stb, scr_ret, sx, beep;
    int miscompares = 0, n_compared = 0, cyc = 0, nk, ns, nr, nx, nb;

    eiom_mapper DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata), .in_pin_i(in_pin), .out_pin_o(out_pin),
        .ctrl_bits_i(ctrl), .notify_bits_o(nfy), .saver_active_i(sav),
        .sys_menu_i(menu), .key_stb_o(key_stb), .key_code_o(key_code),
        .scr_stb_o(scr_stb), .scr_ret_o(scr_ret), .scr_num_o(scr_num),
        .saver_exit_o(sx), .beep_o(beep));
    eiom_unit_model unit (.sys_clk_i(sys_clk_i), .sw_i(sw),
        .out_pin_i(out_pin), .in_pin_o(in_pin), .lamp_o());

    initial forever #12.5 sys_clk_i = ~sys_clk_i;

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] ca(input int t, input logic [1:0] rg);
        return {rg, 4'(t), 2'h0};
    endfunction
    function logic [31:0] cfgw(input logic [4:0] f, input logic [4:0] k,
                               input logic [11:0] an);
        return {4'h0, an, 3'h0, k, 3'h0, f};
    endfunction
    function int exp_k(input int c, input logic m);
        return (c < `EIOM_SYS_KEY_FIRST || m) ? 1 : 0;
    endfunction

    task tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr_i <= 1;
        @(posedge sys_clk_i);
        wr_i <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        rd_i <= 1;
        @(posedge sys_clk_i);
        rd_i <= 0;
        #1 chk(rdata, e);
    endtask
    // held for ten cycles: a long press must still give one event
    task press(input logic [15:0] m);
        {nk, ns, nr, nx, nb} = '0;
        @(posedge sys_clk_i);
        sw <= sw | m;
        repeat (10) @(posedge sys_clk_i);
        nhold = nfy;
        sw <= sw & ~m;
        repeat (8) @(posedge sys_clk_i);
    endtask

    always @(posedge sys_clk_i) begin
        cyc++;
        if (key_stb === 1'b1) begin
            nk++;
            lk = key_code;
        end
        if (scr_stb === 1'b1) begin
            ns++;
            ln = scr_num;
        end
        if (scr_ret === 1'b1) nr++;
        if (sx === 1'b1) nx++;
        if (beep === 1'b1) nb++;
        if (cyc == 6000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        int t;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 0;
        rd(`EIOM_CTRL_OFS, 0);
        rd(`EIOM_OASN_OFS, 0);
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc, 0);
        wr(`EIOM_CTRL_OFS, 32'h0000_0004);
        rd(`EIOM_CTRL_OFS, 32'h0000_0004);
        // every key code on a random terminal, menu mode at random
        for (int c = 0; c <= `EIOM_KEY_LAST; c++) begin
            r = xs();
            t = r[3:0];
            menu <= r[8];
            wr(ca(t, `EIOM_CFG_REGION), cfgw(5'h02, 5'(c), 0));
            press(16'(1) << t);
            chk(nk, exp_k(c, menu));
            if (nk == 1) chk(lk, c);
            chk(nb, 1);
        end
        wr(`EIOM_CTRL_OFS, 0);
        wr(ca(3, `EIOM_CFG_REGION), cfgw(5'h02, 5'h05, 0));
        wr(ca(2, `EIOM_CFG_REGION), cfgw(5'h02, 5'h09, 0));
        press(16'h000c);
        chk(nk, 2);
        chk(nb, 0);
        wr(`EIOM_CTRL_OFS, 32'h0000_0004);
        // notify on several terminals at once, saver active
        sav <= 1;
        wr(ca(0, `EIOM_CFG_REGION), cfgw(5'h01, 0, 0));
        for (int i = 5; i < 12; i++) begin
            wr(ca(i, `EIOM_CFG_REGION), cfgw(5'h01, 0, 0));
        end
        press(16'h0f21);
        chk(nhold, 16'h0f21);
        chk(nfy, 0);
        chk(nx, 0);
        chk(nb, 0);
        wr(ca(6, `EIOM_CFG_REGION), cfgw(5'h11, 0, 0));
        press(16'h0040);
        chk(nx, 1);
        chk(nb, 0);
        wr(ca(7, `EIOM_CFG_REGION), cfgw(5'h10, 0, 0));
        press(16'h0080);
        chk(nx, 1);
        press(16'h0008);
        chk(nx, 1);
        chk(nk, 0);
        sav <= 0;
        // key plus both screen targets on one terminal
        wr(ca(2, `EIOM_CFG_REGION), cfgw(5'h0e, 5'h03, 12'h009));
        wr(ca(2, `EIOM_SCR_REGION), 32'h0000_0007);
        press(16'h0004);
        chk(nk, 0);
        chk(ns, 1);
        chk(ln, 12'h007);
        wr(ca(2, `EIOM_SCR_REGION), 0);
        press(16'h0004);
        chk(nr, 1);
        chk(ns, 0);
        wr(ca(4, `EIOM_CFG_REGION), cfgw(5'h08, 0, 12'h0ab));
        press(16'h0010);
        chk(ln, 12'h0ab);
        // outputs: sixteen-point unit, then mixed unit
        wr(`EIOM_CTRL_OFS, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            r = xs();
            wr(`EIOM_OASN_OFS, {16'h0, r[31:16]});
            ctrl <= r[15:0] ^ r[23:8];
            repeat (3) @(posedge sys_clk_i);
            chk(out_pin, ctrl & r[31:16]);
            repeat (5) @(posedge sys_clk_i);
            chk(out_pin, ctrl & r[31:16]);
        end
        wr(`EIOM_CTRL_OFS, 32'h0000_0002);
        repeat (3) @(posedge sys_clk_i);
        chk(out_pin, {ctrl[7:0] & r[23:16], 8'h00});
        wr(ca(12, `EIOM_CFG_REGION), cfgw(5'h02, 5'h01, 0));
        press(16'h1008);
        chk(nk, 1);
        rd(`EIOM_STAT_OFS, 32'h0003_0000);
        rd(ca(4, `EIOM_CFG_REGION), cfgw(5'h08, 0, 12'h0ab));
        tally_and_finish();
    end
endmodule

// *** bench/eiom_unit_model.sv ***
// behavioural remote expansion unit: switches, sensors and lamps
// assumes switch levels come from the bench on sys_clk_i edges
`timescale 1ns/100ps

module eiom_unit_model (
    input wire logic sys_clk_i,
    input wire logic [15:0] sw_i,
    input wire logic [15:0] out_pin_i,
    output logic [15:0] in_pin_o,
    output logic [15:0] lamp_o
);
    // ----------------------------------------------------------------
    // contacts and lamps
    // ----------------------------------------------------------------
    // one cable cycle of delay, not aligned to the mapper's sampling
    always @(posedge sys_clk_i) begin
        in_pin_o <= #3 sw_i;
    end
    assign lamp_o = out_pin_i;
endmodule

// *** design/eiom_mapper.sv ***
// expanded i/o function mapper: input terminals to controller bits, keys,
// screen switches and saver release; controller bits to output terminals.
// assumes: terminal pins asynchronous, controller bits and status on sys_clk_i
//
// What this block does
// - single-type sixteen point units use expanded numbers 0 to 15
// - mixed unit maps inputs and outputs each to numbers 0 to 7
// - any function may be configured on any terminal freely
// - notify terminal drives its controller bit to mirror the input
// - all simultaneous inputs are reported, none lost
// - key terminal acts as key; system keys only in system menu
// - digits, hex, clear, sign, point, home, arrows and menu accepted
// - key plus per-screen switch on one terminal: switch wins
// - screen number switches screen; number 0 returns to previous
// - per-screen target beats the all-screens target
// - output terminal follows its assigned controller bit
// - output terminal holds its level until the bit changes
// - saver-release terminal turning on wakes the display
// - key or switch terminal always releases the saver
// - notify and unassigned terminals use their own release setting
// - during saver a key or switch only wakes, action suppressed
// - notify changes reach controller even during saver
// - notify terminals never beep
// - other terminals beep according to a stored switch
`timescale 1ns/100ps
`include "eiom_regs.svh"

module eiom_mapper
    import eiom_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [15:0] in_pin_i,
    output logic [15:0] out_pin_o,
    input wire logic [15:0] ctrl_bits_i,
    output logic [15:0] notify_bits_o,
    input wire logic saver_active_i,
    input wire logic sys_menu_i,
    output logic key_stb_o,
    output logic [4:0] key_code_o,
    output logic scr_stb_o,
    output logic scr_ret_o,
    output logic [EIOM_SCR_W-1:0] scr_num_o,
    output logic saver_exit_o,
    output logic beep_o
);

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    // which physical points carry inputs for the fitted unit
    function automatic logic [15:0] in_mask(input logic [1:0] unit);
        case (unit)
            EIOM_UNIT_IN16: in_mask = 16'hFFFF;
            EIOM_UNIT_MIX: in_mask = 16'h00FF;
            default: in_mask = 16'h0000;
        endcase
    endfunction

    // arrows and menu only count in the system menu
    function automatic logic is_sys_key(input logic [4:0] code);
        is_sys_key = (code >= `EIOM_SYS_KEY_FIRST);
    endfunction

    function automatic logic [3:0] first_set(input logic [15:0] v);
        first_set = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    eiom_state_s q, d;

    logic [15:0] imask;
    logic [15:0] rise;
    logic [15:0] ovals;
    logic [3:0] idx;
    logic [31:0] cf;
    logic has_key, has_each, has_all, has_scr, has_notify;
    logic [EIOM_SCR_W-1:0] target;

    always_comb begin
        d = q;
        imask = in_mask(q.ctrl[1:0]);
        // ------------------------------------------------------------------
        // input side
        // ------------------------------------------------------------------
        d.sync1 = in_pin_i;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        rise = q.sync2 & ~q.prev & imask;
        idx = first_set(q.pending);
        cf = q.cfg[idx];
        has_notify = cf[`EIOM_CFG_NOTIFY_BIT];
        has_key = cf[`EIOM_CFG_KEY_BIT];
        has_each = cf[`EIOM_CFG_SCR_EACH_BIT];
        has_all = cf[`EIOM_CFG_SCR_ALL_BIT];
        has_scr = has_each | has_all;
        // per-screen slot is reloaded by display logic on each screen change
        target = has_each ? q.scr[idx] :
            cf[`EIOM_CFG_ALLNUM_LSB +: EIOM_SCR_W];
        // every notify terminal mirrored in parallel, saver or not
        for (int i = 0; i < EIOM_TERMS; i++) begin
            d.notify[i] = q.sync2[i] & imask[i] &
                q.cfg[i][`EIOM_CFG_NOTIFY_BIT];
        end

        d.key_stb = 1'b0;
        d.scr_stb = 1'b0;
        d.scr_ret = 1'b0;
        d.saver_exit = 1'b0;
        d.beep = 1'b0;
        // one edge served per cycle; edges queue in pending, none dropped
        if (q.pending != 16'h0000) begin
            d.last_idx = idx;
            if (saver_active_i) begin
                // wake only, the key or switch itself is swallowed
                d.saver_exit = (has_key | has_scr) |
                    cf[`EIOM_CFG_SAVER_BIT];
            end else if (has_scr) begin
                // switch beats key on a shared terminal
                d.scr_num = target;
                d.scr_ret = (target == '0);
                d.scr_stb = (target != '0);
            end else if (has_key) begin
                d.key_code = cf[`EIOM_CFG_KEY_LSB +: 5];
                d.key_stb = !is_sys_key(d.key_code) | sys_menu_i;
            end
            d.beep = !has_notify & q.ctrl[`EIOM_CTRL_BEEP_BIT];
        end
        // a new edge on the served terminal survives its clear
        d.pending = (q.pending & ~(16'h0001 << idx)) | rise;

        // ------------------------------------------------------------------
        // output side
        // ------------------------------------------------------------------
        ovals = ctrl_bits_i & q.oasn;
        case (eiom_unit_e'(q.ctrl[1:0]))
            EIOM_UNIT_OUT16: d.out_pin = ovals;
            EIOM_UNIT_MIX: d.out_pin = {ovals[7:0], 8'h00};
            default: d.out_pin = 16'h0000;
        endcase

        // ------------------------------------------------------------------
        // register port
        // ------------------------------------------------------------------
        d.rdata = 32'h0000_0000;
        if (wr_i) begin
            if (addr_i == `EIOM_CTRL_OFS) begin
                d.ctrl = wdata_i[2:0];
            end else if (addr_i == `EIOM_OASN_OFS) begin
                d.oasn = wdata_i[15:0];
            end else if (addr_i[7:6] == `EIOM_CFG_REGION) begin
                d.cfg[addr_i[5:2]] = wdata_i;
            end else if (addr_i[7:6] == `EIOM_SCR_REGION) begin
                d.scr[addr_i[5:2]] = wdata_i[EIOM_SCR_W-1:0];
            end
        end
        if (rd_i) begin
            if (addr_i == `EIOM_CTRL_OFS) begin
                d.rdata = {29'h0000_0000, q.ctrl};
            end else if (addr_i == `EIOM_STAT_OFS) begin
                d.rdata = {12'h000, q.last_idx, q.sync2 & imask};
            end else if (addr_i == `EIOM_OASN_OFS) begin
                d.rdata = {16'h0000, q.oasn};
            end else if (addr_i[7:6] == `EIOM_CFG_REGION) begin
                d.rdata = q.cfg[addr_i[5:2]];
            end else if (addr_i[7:6] == `EIOM_SCR_REGION) begin
                d.rdata = {20'h0_0000, q.scr[addr_i[5:2]]};
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign out_pin_o = q.out_pin;
    assign notify_bits_o = q.notify;
    assign key_stb_o = q.key_stb;
    assign key_code_o = q.key_code;
    assign scr_stb_o = q.scr_stb;
    assign scr_ret_o = q.scr_ret;
    assign scr_num_o = q.scr_num;
    assign saver_exit_o = q.saver_exit;
    assign beep_o = q.beep;

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    logic [15:0] beep_cfg_notify;
    always_comb begin
        for (int i = 0; i < EIOM_TERMS; i++) begin
            beep_cfg_notify[i] = q.cfg[i][`EIOM_CFG_NOTIFY_BIT];
        end
    end

    property p_no_beep_notify;
        @(posedge sys_clk_i) disable iff (rst_i)
        beep_o |-> !beep_cfg_notify[q.last_idx];
    endproperty
    a_no_beep_notify: assert property (p_no_beep_notify)
        else $error("beep for a notify terminal");

    property p_saver_swallows;
        @(posedge sys_clk_i) disable iff (rst_i)
        (key_stb_o || scr_stb_o || scr_ret_o) |-> !$past(saver_active_i);
    endproperty
    a_saver_swallows: assert property (p_saver_swallows)
        else $error("key or switch action taken during saver");

    property p_exit_needs_saver;
        @(posedge sys_clk_i) disable iff (rst_i)
        saver_exit_o |-> $past(saver_active_i) && $past(q.pending != 0);
    endproperty
    a_exit_needs_saver: assert property (p_exit_needs_saver)
        else $error("saver exit without saver and press");

    property p_sys_key_menu;
        @(posedge sys_clk_i) disable iff (rst_i)
        (key_stb_o && key_code_o >= `EIOM_SYS_KEY_FIRST) |-> $past(sys_menu_i);
    endproperty
    a_sys_key_menu: assert property (p_sys_key_menu)
        else $error("system key outside system menu");

    property p_switch_over_key;
        @(posedge sys_clk_i) disable iff (rst_i)
        (scr_stb_o || scr_ret_o) |-> !key_stb_o && !(scr_stb_o && scr_ret_o);
    endproperty
    a_switch_over_key: assert property (p_switch_over_key)
        else $error("key and switch fired together");

    property p_return_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        scr_ret_o |-> scr_num_o == '0;
    endproperty
    a_return_zero: assert property (p_return_zero)
        else $error("screen return with nonzero number");

    property p_out_follow;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($past(ce_i) && $past(q.ctrl[1:0]) == EIOM_UNIT_OUT16)
            |-> out_pin_o == $past(ctrl_bits_i & q.oasn);
    endproperty
    a_out_follow: assert property (p_out_follow)
        else $error("output terminal not following its bit");

    property p_out_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($stable(ctrl_bits_i) && $stable(q.oasn) && $stable(q.ctrl))
            ##1 $stable(ctrl_bits_i) |-> $stable(out_pin_o);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("output terminal changed with stable bit");

    property p_mix_upper_quiet;
        @(posedge sys_clk_i) disable iff (rst_i)
        (q.ctrl[1:0] == EIOM_UNIT_MIX && ce_i) ##1 ce_i
            |-> notify_bits_o[15:8] == 8'h00 && out_pin_o[7:0] == 8'h00;
    endproperty
    a_mix_upper_quiet: assert property (p_mix_upper_quiet)
        else $error("mixed unit uses wrong points");

    property p_notify_mirror;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && q.ctrl[1:0] == EIOM_UNIT_IN16 && q.cfg[0][0]) ##1
            (ce_i && $stable(q.cfg[0]) && $stable(q.ctrl))
            |=> notify_bits_o[0] == $past(q.sync2[0]);
    endproperty
    a_notify_mirror: assert property (p_notify_mirror)
        else $error("notify bit not mirroring terminal");

    // ----------------------------------------------------------------------
    // checks on unit modes, saver, beep, the edge queue and read data
    // ----------------------------------------------------------------------
    // consequents look one registered step back; ce_i low in that step
    // would leave a frozen output that only looks stale

    property p_in16_quiet_out;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($past(ce_i) && $past(q.ctrl[1:0]) == EIOM_UNIT_IN16)
            |-> out_pin_o == 16'h0000;
    endproperty
    a_in16_quiet_out: assert property (p_in16_quiet_out)
        else $error("input unit drives an output terminal");

    property p_out16_quiet_in;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($past(ce_i) && $past(q.ctrl[1:0]) == EIOM_UNIT_OUT16)
            |-> notify_bits_o == 16'h0000;
    endproperty
    a_out16_quiet_in: assert property (p_out16_quiet_in)
        else $error("output unit reports an input");

    property p_mix_out_follow;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($past(ce_i) && $past(q.ctrl[1:0]) == EIOM_UNIT_MIX)
            |-> out_pin_o[15:8] == $past(ctrl_bits_i[7:0] & q.oasn[7:0]);
    endproperty
    a_mix_out_follow: assert property (p_mix_out_follow)
        else $error("mixed unit output not following its bit");

    property p_key_wakes;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($past(ce_i) && $past(saver_active_i) && $past(q.pending != 16'h0000)
            && $past(has_key || has_scr)) |-> saver_exit_o;
    endproperty
    a_key_wakes: assert property (p_key_wakes)
        else $error("key or switch terminal left the saver on");

    property p_plain_no_wake;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($past(ce_i) && $past(saver_active_i) && $past(q.pending != 16'h0000)
            && $past(!has_key && !has_scr && !cf[`EIOM_CFG_SAVER_BIT]))
            |-> !saver_exit_o;
    endproperty
    a_plain_no_wake: assert property (p_plain_no_wake)
        else $error("terminal without release setting woke the saver");

    property p_wake_only;
        @(posedge sys_clk_i) disable iff (rst_i)
        saver_exit_o |-> !key_stb_o && !scr_stb_o && !scr_ret_o;
    endproperty
    a_wake_only: assert property (p_wake_only)
        else $error("action taken together with saver exit");

    property p_beep_needs_press;
        @(posedge sys_clk_i) disable iff (rst_i)
        (beep_o && $past(ce_i))
            |-> $past(q.pending != 16'h0000)
            && $past(q.ctrl[`EIOM_CTRL_BEEP_BIT]);
    endproperty
    a_beep_needs_press: assert property (p_beep_needs_press)
        else $error("beep without press or with sound off");

    property p_edge_only_pending;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(ce_i) |-> (q.pending & ~$past(q.pending) & ~$past(rise))
            == 16'h0000;
    endproperty
    a_edge_only_pending: assert property (p_edge_only_pending)
        else $error("press queued without an off-to-on edge");

    property p_served_only_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        $past(ce_i) |-> ($past(q.pending) & ~q.pending
            & ~(16'h0001 << $past(idx))) == 16'h0000;
    endproperty
    a_served_only_clear: assert property (p_served_only_clear)
        else $error("queued press dropped without service");

    property p_rdata_idle;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($past(ce_i) && !$past(rd_i)) |-> rdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside the cycle after a read");

endmodule

// *** design/eiom_pkg.sv ***
// types of the expanded i/o function mapper
// assumes eiom_regs.svh supplies the numeric constants
package eiom_pkg;

    localparam int EIOM_TERMS = 16;
    localparam int EIOM_SCR_W = 12;

    // unit fitted on the expansion cable
    typedef enum logic [1:0] {
        EIOM_UNIT_IN16 = 2'h0,
        EIOM_UNIT_OUT16 = 2'h1,
        EIOM_UNIT_MIX = 2'h2
    } eiom_unit_e;

    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] prev;
        logic [15:0] pending;
        logic [15:0][31:0] cfg;
        logic [15:0][EIOM_SCR_W-1:0] scr;
        logic [2:0] ctrl;
        logic [15:0] oasn;
        logic [15:0] out_pin;
        logic [15:0] notify;
        logic [31:0] rdata;
        logic [3:0] last_idx;
        logic key_stb;
        logic [4:0] key_code;
        logic scr_stb;
        logic scr_ret;
        logic [EIOM_SCR_W-1:0] scr_num;
        logic saver_exit;
        logic beep;
    } eiom_state_s;

endpackage

// *** design/eiom_regs.svh ***
// register offsets, field positions and reset values of the expanded i/o
// function mapper; assumes 8-bit byte addresses on the plain register port
`ifndef EIOM_REGS_SVH
`define EIOM_REGS_SVH

// --------------------------------------------------------------------------
// offsets
// --------------------------------------------------------------------------
`define EIOM_CTRL_OFS 8'h00
`define EIOM_STAT_OFS 8'h04
`define EIOM_OASN_OFS 8'h08
`define EIOM_CFG_REGION 2'h1
`define EIOM_SCR_REGION 2'h2

// --------------------------------------------------------------------------
// fields
// --------------------------------------------------------------------------
`define EIOM_CTRL_UNIT_LSB 0
`define EIOM_CTRL_BEEP_BIT 2
`define EIOM_CFG_NOTIFY_BIT 0
`define EIOM_CFG_KEY_BIT 1
`define EIOM_CFG_SCR_EACH_BIT 2
`define EIOM_CFG_SCR_ALL_BIT 3
`define EIOM_CFG_SAVER_BIT 4
`define EIOM_CFG_KEY_LSB 8
`define EIOM_CFG_ALLNUM_LSB 16
`define EIOM_SYS_KEY_FIRST 5'h14
`define EIOM_KEY_LAST 5'h18

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define EIOM_CTRL_RST 3'h0
`define EIOM_OASN_RST 16'h0000

`endif
